// ==== src/tes_ctrl.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// Contract
// [RULE1] free-run: continuous frames, trigger ignored
// [RULE2] master: trigger starts programmed exposure, one frame
// [RULE3] slave: exposure lasts while trigger asserted
// [RULE4] trigger source is cc1 or external
// [RULE5] trigger polarity selectable low or high
// [RULE6] exposure settable 100 us to 7000 ms
// [RULE7] programmed exposure unused in slave mode
// [RULE8] strobe asserted during each exposure
// [RULE9] strobe polarity selectable low or high
// [RULE10] triggers during exposure or readout ignored
module tes_ctrl #(
    // exposure in microseconds after reset; shorter values keep test runs brief
    parameter logic [tes_pkg::EXP_W-1:0] EXP_RST = tes_pkg::EXP_RST_US
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // trigger pins
    input  wire logic        cc1_trig,
    input  wire logic        ext_trig,
    // sensor side
    output logic             expose,
    output logic             frame_start,
    input  wire logic        readout_done,
    // strobe pin
    output logic             strobe_out
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic is_mapped(input logic [7:0] a);
        return a == tes_pkg::OFS_CTRL || a == tes_pkg::OFS_EXPO ||
               a == tes_pkg::OFS_STATUS || a == tes_pkg::OFS_FCOUNT;
    endfunction : is_mapped

    ////////////////////////////////////////////////////////////////////////////////
    logic                 trig_level;
    logic                 trig_rise;
    tes_pkg::tes_cfg_t    cfg_reg, cfg_next;
    logic [tes_pkg::EXP_W-1:0] exp_reg, exp_next;
    logic                 aw_full_reg, aw_full_next;
    logic [7:0]           awaddr_reg, awaddr_next;
    logic                 w_full_reg, w_full_next;
    logic [31:0]          wdata_reg, wdata_next;
    logic [3:0]           wstrb_reg, wstrb_next;
    logic                 bvalid_reg, bvalid_next;
    logic [1:0]           bresp_reg, bresp_next;
    logic                 rvalid_reg, rvalid_next;
    logic [31:0]          rdata_reg, rdata_next;
    logic [1:0]           rresp_reg, rresp_next;
    tes_pkg::tes_state_t  state_reg, state_next;
    logic [1:0]           run_mode_reg, run_mode_next;
    logic [tes_pkg::EXP_W-1:0] exp_lat_reg, exp_lat_next;
    logic [7:0]           pre_reg, pre_next;
    logic [tes_pkg::EXP_W-1:0] us_reg, us_next;
    logic [tes_pkg::FCOUNT_W-1:0] fcnt_reg, fcnt_next;
    logic                 expose_reg, expose_next;
    logic                 fstart_reg, fstart_next;
    logic                 strobe_reg, strobe_next;

    tes_trig_sync u_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .cc1_trig   (cc1_trig),
        .ext_trig   (ext_trig),
        .trig_src   (cfg_reg.trig_src),
        .trig_pol   (cfg_reg.trig_pol),
        .trig_level (trig_level),
        .trig_rise  (trig_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register bus: address and data may come in either order, one write at a time
    logic        have_aw, have_w, do_wr;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data, merged;
    logic [3:0]  wr_strb;

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;

    always_comb begin
        have_aw = aw_full_reg || (s_axi_awvalid && s_axi_awready);
        have_w = w_full_reg || (s_axi_wvalid && s_axi_wready);
        do_wr = have_aw && have_w;
        wr_addr = aw_full_reg ? awaddr_reg : s_axi_awaddr;
        wr_data = w_full_reg ? wdata_reg : s_axi_wdata;
        wr_strb = w_full_reg ? wstrb_reg : s_axi_wstrb;
        aw_full_next = have_aw && !do_wr;
        w_full_next = have_w && !do_wr;
        awaddr_next = aw_full_reg ? awaddr_reg : s_axi_awaddr;
        wdata_next = wr_data;
        wstrb_next = wr_strb;
        cfg_next = cfg_reg;
        exp_next = exp_reg;
        merged = 32'h0;
        bvalid_next = bvalid_reg && !s_axi_bready;
        bresp_next = bresp_reg;
        if (do_wr) begin
            bvalid_next = 1'h1;
            bresp_next = is_mapped(wr_addr) ? tes_pkg::RESP_OKAY : tes_pkg::RESP_SLVERR;
            if (wr_addr == tes_pkg::OFS_CTRL) begin
                merged = merge({27'h0, cfg_reg}, wr_data, wr_strb);
                cfg_next = tes_pkg::tes_cfg_t'(merged[tes_pkg::CFG_W-1:0]);
            end else if (wr_addr == tes_pkg::OFS_EXPO) begin
                merged = merge({9'h0, exp_reg}, wr_data, wr_strb);
                // out-of-range values saturate rather than being refused
                if (merged < {9'h0, tes_pkg::EXP_MIN_US}) exp_next = tes_pkg::EXP_MIN_US; // RULE6
                else if (merged > {9'h0, tes_pkg::EXP_MAX_US}) exp_next = tes_pkg::EXP_MAX_US;
                else exp_next = merged[tes_pkg::EXP_W-1:0];
            end
        end
        rvalid_next = rvalid_reg && !s_axi_rready;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'h1;
            rresp_next = is_mapped(s_axi_araddr) ? tes_pkg::RESP_OKAY : tes_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                tes_pkg::OFS_CTRL:   rdata_next = {27'h0, cfg_reg};
                tes_pkg::OFS_EXPO:   rdata_next = {9'h0, exp_reg};
                tes_pkg::OFS_STATUS: rdata_next = {28'h0, trig_level, state_reg};
                tes_pkg::OFS_FCOUNT: rdata_next = {16'h0, fcnt_reg};
                default:             rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'h0;
            w_full_reg  <= 1'h0;
            awaddr_reg  <= 8'h0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            cfg_reg     <= tes_pkg::CFG_RST;
            exp_reg     <= EXP_RST;
            bvalid_reg  <= 1'h0;
            bresp_reg   <= tes_pkg::RESP_OKAY;
            rvalid_reg  <= 1'h0;
            rdata_reg   <= 32'h0;
            rresp_reg   <= tes_pkg::RESP_OKAY;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            cfg_reg     <= cfg_next;
            exp_reg     <= exp_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp  = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // exposure sequencer; mode and time are latched so a mid-frame write to either is harmless
    logic start, us_tick, timed_done;

    always_comb begin
        state_next = state_reg;
        run_mode_next = run_mode_reg;
        exp_lat_next = exp_lat_reg;
        pre_next = pre_reg;
        us_next = us_reg;
        fcnt_next = fcnt_reg;
        fstart_next = 1'h0;
        start = 1'h0;
        us_tick = pre_reg == 8'(tes_pkg::US_CYCLES - 1);
        timed_done = us_tick && (us_reg + 23'h1 == exp_lat_reg);
        case (state_reg)
            tes_pkg::ST_IDLE: begin
                if (cfg_reg.mode == tes_pkg::MODE_SLAVE || cfg_reg.mode == tes_pkg::MODE_MASTER)
                    start = trig_rise; // RULE2
                else
                    start = 1'h1; // RULE1
                if (start) begin
                    state_next = tes_pkg::ST_EXPOSE;
                    run_mode_next = cfg_reg.mode;
                    exp_lat_next = exp_reg;
                    pre_next = 8'h0;
                    us_next = 23'h0;
                end
            end
            tes_pkg::ST_EXPOSE: begin
                pre_next = us_tick ? 8'h0 : pre_reg + 8'h1;
                us_next = us_tick ? us_reg + 23'h1 : us_reg;
                if (run_mode_reg == tes_pkg::MODE_SLAVE ? !trig_level : timed_done) begin // RULE3 RULE7
                    state_next = tes_pkg::ST_READ;
                    fstart_next = 1'h1;
                    fcnt_next = fcnt_reg + 16'h1;
                end
            end
            tes_pkg::ST_READ: begin
                // triggers are not looked at until the readout finishes
                if (readout_done) state_next = tes_pkg::ST_IDLE; // RULE10
            end
            default: state_next = tes_pkg::ST_IDLE;
        endcase
        expose_next = state_next == tes_pkg::ST_EXPOSE; // RULE8
        strobe_next = expose_next ~^ cfg_next.strobe_pol; // RULE9
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= tes_pkg::ST_IDLE;
            run_mode_reg <= tes_pkg::MODE_FREE;
            exp_lat_reg  <= EXP_RST;
            pre_reg      <= 8'h0;
            us_reg       <= 23'h0;
            fcnt_reg     <= 16'h0;
            expose_reg   <= 1'h0;
            fstart_reg   <= 1'h0;
            strobe_reg   <= ~tes_pkg::CFG_RST.strobe_pol;
        end else begin
            state_reg    <= state_next;
            run_mode_reg <= run_mode_next;
            exp_lat_reg  <= exp_lat_next;
            pre_reg      <= pre_next;
            us_reg       <= us_next;
            fcnt_reg     <= fcnt_next;
            expose_reg   <= expose_next;
            fstart_reg   <= fstart_next;
            strobe_reg   <= strobe_next;
        end
    end

    assign expose      = expose_reg;
    assign frame_start = fstart_reg;
    assign strobe_out  = strobe_reg;

    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] len_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) len_reg <= 32'h0;
        else len_reg <= (state_reg == tes_pkg::ST_EXPOSE) ? len_reg + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_free_restarts: assert property ( // RULE1
        state_reg == tes_pkg::ST_IDLE && cfg_reg.mode == tes_pkg::MODE_FREE
        |=> state_reg == tes_pkg::ST_EXPOSE) else $error("free-run did not restart");
    chk_timed_length: assert property ( // RULE2
        state_reg == tes_pkg::ST_EXPOSE && state_next == tes_pkg::ST_READ &&
        run_mode_reg != tes_pkg::MODE_SLAVE
        |-> len_reg + 32'h1 == 32'(exp_lat_reg) * 32'(tes_pkg::US_CYCLES))
        else $error("timed exposure length wrong");
    chk_slave_holds: assert property ( // RULE7
        state_reg == tes_pkg::ST_EXPOSE && run_mode_reg == tes_pkg::MODE_SLAVE && trig_level
        |=> state_reg == tes_pkg::ST_EXPOSE) else $error("slave exposure ended early");
    chk_slave_ends: assert property ( // RULE3
        state_reg == tes_pkg::ST_EXPOSE && run_mode_reg == tes_pkg::MODE_SLAVE && !trig_level
        |=> state_reg == tes_pkg::ST_READ ##0 frame_start) else $error("slave exposure overran");
    chk_exp_range: assert property ( // RULE6
        exp_reg >= tes_pkg::EXP_MIN_US && exp_reg <= tes_pkg::EXP_MAX_US)
        else $error("exposure time out of range");
    chk_strobe_follows: assert property ( // RULE8
        strobe_out == (expose ~^ cfg_reg.strobe_pol) &&
        expose == (state_reg == tes_pkg::ST_EXPOSE)) else $error("strobe not tracking exposure");
    chk_trig_ignored: assert property ( // RULE10
        state_reg == tes_pkg::ST_READ && trig_rise && !readout_done
        |=> state_reg == tes_pkg::ST_READ) else $error("trigger accepted during readout");
    chk_one_frame: assert property ( // RULE2
        frame_start |-> state_reg == tes_pkg::ST_READ ##1 !frame_start)
        else $error("frame start not single");
    chk_master_waits: assert property ( // RULE2
        state_reg == tes_pkg::ST_IDLE && cfg_reg.mode == tes_pkg::MODE_MASTER && !trig_rise
        |=> state_reg == tes_pkg::ST_IDLE) else $error("master exposed without trigger");

    cov_free_frame:   cover property (run_mode_reg == tes_pkg::MODE_FREE && frame_start);
    cov_master_frame: cover property (run_mode_reg == tes_pkg::MODE_MASTER && frame_start);
    cov_slave_frame:  cover property (run_mode_reg == tes_pkg::MODE_SLAVE && frame_start);
endmodule : tes_ctrl

// ==== src/tes_pkg.sv ====
package tes_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_US     = 1000;
    localparam int US_CYCLES     = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // exposure time in microseconds
    localparam int               EXP_W      = 23;
    localparam logic [EXP_W-1:0] EXP_MIN_US = 23'h000064;
    localparam logic [EXP_W-1:0] EXP_MAX_US = 23'h6acfc0;
    localparam logic [EXP_W-1:0] EXP_RST_US = 23'h002710;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_EXPO   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FCOUNT = 8'h0c;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // trigger modes
    localparam logic [1:0] MODE_FREE   = 2'h0;
    localparam logic [1:0] MODE_MASTER = 2'h1;
    localparam logic [1:0] MODE_SLAVE  = 2'h2;

    localparam int FCOUNT_W = 16;
    localparam int CFG_W    = 5;

    typedef struct packed {
        logic       strobe_pol;
        logic       trig_pol;
        logic       trig_src;
        logic [1:0] mode;
    } tes_cfg_t;

    localparam tes_cfg_t CFG_RST = '{strobe_pol: 1'h1, trig_pol: 1'h1, trig_src: 1'h0,
                                     mode: MODE_FREE};

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_EXPOSE = 3'h2,
        ST_READ   = 3'h4
    } tes_state_t;
endpackage : tes_pkg

// ==== src/tes_trig_sync.sv ====
`timescale 1ns/1ps
module tes_trig_sync (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // trigger pins
    input  wire logic cc1_trig,
    input  wire logic ext_trig,
    // selection
    input  wire logic trig_src,
    input  wire logic trig_pol,
    // qualified trigger
    output logic      trig_level,
    output logic      trig_rise
);
    logic [1:0] meta_reg, meta_next;
    logic [1:0] sync_reg, sync_next;
    logic       level_reg, level_next;
    logic       rise_reg, rise_next;
    logic       selected;

    always_comb begin
        meta_next = {ext_trig, cc1_trig};
        sync_next = meta_reg;
        selected = trig_src ? sync_reg[1] : sync_reg[0]; // RULE4
        level_next = selected ~^ trig_pol; // RULE5
        // a source or polarity change may show as one spurious edge
        rise_next = level_next && !level_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg  <= 2'h0;
            sync_reg  <= 2'h0;
            level_reg <= 1'h0;
            rise_reg  <= 1'h0;
        end else begin
            meta_reg  <= meta_next;
            sync_reg  <= sync_next;
            level_reg <= level_next;
            rise_reg  <= rise_next;
        end
    end

    assign trig_level = level_reg;
    assign trig_rise  = rise_reg;

    chk_route_polarity: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        level_reg == ($past(trig_src) ? $past(sync_reg[1]) : $past(sync_reg[0]))
                     ~^ $past(trig_pol))
        else $error("trigger level does not follow source and polarity");
endmodule : tes_trig_sync

// ==== tb/tb_trigger_exposure_strobe_ctrl.sv ====
`timescale 1ns/1ps
module tb_trigger_exposure_strobe_ctrl;
    // six timed exposures of 12500 cycles dominate the run
    localparam int TMO = 90000;
    localparam int XP  = 100 * tes_pkg::US_CYCLES;
    localparam logic [tes_pkg::EXP_W-1:0] RST_US = tes_pkg::EXP_MIN_US;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0]  wstrb = 4'hf;
    logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, exp_prev = 1'b0;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, expose, frame_start, readout_done;
    logic        strobe_out, cc1_trig, ext_trig;
    logic [1:0]  bresp, rresp, rr;
    logic [15:0] rd_wait = 16'h0003;
    int          err_count = 0, n_tests = 0, cyc = 0, run = 0, last_len = 0, nexp = 0, nfr = 0;

    initial forever #4 aclk = ~aclk;

    tes_ctrl #(.EXP_RST(RST_US)) uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_rdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(w_v),
        .s_axi_wready(w_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .cc1_trig(cc1_trig), .ext_trig(ext_trig), .expose(expose), .frame_start(frame_start),
        .readout_done(readout_done), .strobe_out(strobe_out));

    tes_grabber_model src (.aclk(aclk), .frame_start(frame_start), .rd_wait(rd_wait),
        .readout_done(readout_done), .cc1_trig(cc1_trig), .ext_trig(ext_trig));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk

    // exposure length and frame monitor; a hang ends at the cycle ceiling
    always @(posedge aclk) begin
        cyc      <= cyc + 1;
        exp_prev <= expose;
        if (frame_start === 1'b1) nfr <= nfr + 1;
        if (expose === 1'b1) begin
            run <= run + 1;
        end else if (exp_prev === 1'b1) begin
            last_len <= run;
            run      <= 0;
            nexp     <= nexp + 1;
        end
        if (cyc == TMO) begin
            err_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata  <= d;
        aw_v   <= 1'b1;
        w_v    <= 1'b1;
        b_r    <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && aw_rdy === 1'b1) begin
                ad = 1'b1;
                aw_v <= 1'b0;
            end
            if (!wd && w_rdy === 1'b1) begin
                wd = 1'b1;
                w_v <= 1'b0;
            end
        end
        do @(posedge aclk); while (b_v !== 1'b1);
        rr = bresp;
        b_r <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        ar_v   <= 1'b1;
        r_r    <= 1'b1;
        do @(posedge aclk); while (ar_rdy !== 1'b1);
        ar_v <= 1'b0;
        do @(posedge aclk); while (r_v !== 1'b1);
        rv = rdata;
        rr = rresp;
        r_r <= 1'b0;
    endtask : axi_rd

    task automatic wait_exp(input int n);
        while (nexp < n) @(posedge aclk);
    endtask : wait_exp

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        axi_rd(tes_pkg::OFS_CTRL);
        chk("ctrl_rst", 32'h18, rv);
        axi_rd(tes_pkg::OFS_EXPO);
        chk("expo_rst", RST_US, rv);
        axi_rd(8'h10);
        chk("unmapped_resp", tes_pkg::RESP_SLVERR, rr);
        chk("unmapped_data", 32'h0, rv);
        axi_rd(tes_pkg::OFS_STATUS);
        chk("state_expose", 32'h2, rv[2:0]);
        chk("strobe_hi", 32'h1, strobe_out);
        axi_wr(tes_pkg::OFS_EXPO, 32'h0);
        axi_rd(tes_pkg::OFS_EXPO);
        chk("expo_min", tes_pkg::EXP_MIN_US, rv);
        axi_wr(tes_pkg::OFS_EXPO, 32'hffffffff);
        axi_rd(tes_pkg::OFS_EXPO);
        chk("expo_max", tes_pkg::EXP_MAX_US, rv);
        axi_wr(tes_pkg::OFS_EXPO, 32'h64);
        axi_wr(tes_pkg::OFS_STATUS, 32'h0);
        chk("ro_resp", tes_pkg::RESP_OKAY, rr);
    endtask : t_regs

    task automatic t_free();
        wait_exp(1);
        chk("len_rst", RST_US * tes_pkg::US_CYCLES, last_len);
        src.pulse(1'b0, 1'b1, 40);
        wait_exp(2);
        chk("len_free", XP, last_len);
        while (expose !== 1'b1) @(posedge aclk);
        // polarity flips are done mid-exposure so the spurious edge is ignored
        src.set_idle(1'b0);
        axi_wr(tes_pkg::OFS_CTRL, 32'h05);
        wait_exp(3);
        chk("len_free2", XP, last_len);
    endtask : t_free

    task automatic t_master();
        repeat (40) @(posedge aclk);
        chk("wait_trig", 32'h0, expose);
        chk("frames", nexp, nfr);
        src.pulse(1'b1, 1'b0, 50);
        chk("expose_ext", 32'h1, expose);
        chk("strobe_lo", 32'h0, strobe_out);
        src.pulse(1'b1, 1'b0, 20);
        wait_exp(4);
        chk("len_master", XP, last_len);
        repeat (40) @(posedge aclk);
        chk("no_requeue", 32'h0, expose);
        chk("strobe_idle", 32'h1, strobe_out);
        chk("one_frame", nexp, nfr);
        src.pulse(1'b0, 1'b0, 50);
        chk("unselected", 32'h0, expose);
        src.pulse(1'b1, 1'b0, 50);
        src.set_idle(1'b1);
        axi_wr(tes_pkg::OFS_CTRL, 32'h09);
        wait_exp(5);
        repeat (40) @(posedge aclk);
        src.pulse(1'b0, 1'b1, 50);
        chk("expose_cc1", 32'h1, expose);
        wait_exp(6);
        repeat (40) @(posedge aclk);
    endtask : t_master

    task automatic t_slave();
        axi_wr(tes_pkg::OFS_CTRL, 32'h1a);
        rd_wait <= 16'h00c8;
        src.pulse(1'b0, 1'b1, 300);
        wait_exp(7);
        chk("len_slave", 32'd300, last_len);
        while (nfr < 7) @(posedge aclk);
        src.pulse(1'b0, 1'b1, 30);
        repeat (300) @(posedge aclk);
        chk("readout_busy", 32'h0, expose);
        chk("exp_count", 32'd7, nexp);
        axi_rd(tes_pkg::OFS_FCOUNT);
        chk("fcount", nfr, rv[15:0]);
        // mode code 3 must behave as free-run and start at once
        axi_wr(tes_pkg::OFS_CTRL, 32'h1b);
        axi_rd(tes_pkg::OFS_STATUS);
        chk("mode3_free", 32'h2, rv[2:0]);
    endtask : t_slave

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_free();
        t_master();
        t_slave();
        end_sim();
    end
endmodule : tb_trigger_exposure_strobe_ctrl

// ==== tb/tes_grabber_model.sv ====
`timescale 1ns/1ps
module tes_grabber_model (
    // clock
    input  wire logic        aclk,
    // sensor handshake
    input  wire logic        frame_start,
    input  wire logic [15:0] rd_wait,
    output logic             readout_done,
    // trigger pins
    output logic             cc1_trig,
    output logic             ext_trig
);
    logic [15:0] cnt;
    logic        busy;

    initial begin
        cc1_trig     = 1'b0;
        ext_trig     = 1'b0;
        readout_done = 1'b0;
        busy         = 1'b0;
        cnt          = 16'h0000;
    end

    // both pins rest at the inactive level of the chosen polarity
    task automatic set_idle(input logic act);
        @(posedge aclk);
        cc1_trig <= ~act;
        ext_trig <= ~act;
    endtask : set_idle

    // the source alone decides the pulse width, which sets a slave exposure
    task automatic pulse(input logic sel, input logic act, input int width);
        @(posedge aclk);
        if (sel) ext_trig <= act; else cc1_trig <= act;
        repeat (width) @(posedge aclk);
        if (sel) ext_trig <= ~act; else cc1_trig <= ~act;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    // readout ends rd_wait+1 cycles after frame_start is seen; slow values stall
    always @(posedge aclk) begin
        readout_done <= 1'b0;
        if (frame_start === 1'b1) begin
            busy <= 1'b1;
            cnt  <= rd_wait;
        end else if (busy && cnt == 16'h0000) begin
            busy         <= 1'b0;
            readout_done <= 1'b1;
        end else if (busy) begin
            cnt <= cnt - 16'h0001;
        end
    end
endmodule : tes_grabber_model
